// ==== trm_matrix.v ====
// Purpose: Routing matrix between 40 front-panel terminals, eight counters and the DI/DO timing engines
// Assumes: AHB-Lite slave, single word transfers, counter outputs on hclk
// Notes:   Zero wait state; every transfer answers OKAY
// What this block does
// - Counter k source defaults to terminal 39-4k
// - Counter k direction/B defaults to terminal 37-4k
// - Counter k gate/index defaults to terminal 38-4k
// - Counter k output defaults onto terminal 36-4k
// - Software may replace every default route
// - Each counter has eight routable inputs
// - Functional selectors map onto fixed counter inputs
// - Pause and pulse selections use the gate
// - Frequency terminal: gate one-counter, source two-counter
// - Forty terminals, each input, output or timing
// - Timing index 0-39; static bits in two ports
// - Every terminal input has its own debounce filter
// - Any terminal reaches every counter and engine input
// - Input polarity and edge/level sensing are configurable
// - Filter passes after N samples; off at reset
// - Output sample clock is inverted onto terminals
`timescale 1ns/1ps
`include "trm_defines.vh"

module trm_matrix (
   input  wire        hclk,                     // System clock, 20 MHz
   input  wire        hresetn,                  // Async reset, active low
   input  wire        hsel,                     // Slave select
   input  wire [31:0] haddr,                    // Byte address
   input  wire [1:0]  htrans,                   // Transfer type
   input  wire        hwrite,                   // Write when high
   input  wire [2:0]  hsize,                    // Transfer size
   input  wire [31:0] hwdata,                   // Write data
   input  wire        hready,                   // Bus ready
   output reg         hreadyout,                // Slave ready
   output reg         hresp,                    // Response, always OKAY
   output reg  [31:0] hrdata,                   // Read data
   input  wire [39:0] programmable_terminal_in, // Terminal pin levels
   output reg  [39:0] programmable_terminal_out,// Terminal drive levels
   output reg  [39:0] programmable_terminal_oe, // Terminal driver enables
   input  wire [7:0]  counter_output,           // Counter internal outputs
   input  wire        output_sample_clock,      // DO sample clock from engine
   output wire [7:0]  counter_source_input,     // Routed source per counter
   output wire [7:0]  counter_gate_input,       // Routed gate per counter
   output wire [7:0]  counter_auxiliary_input,  // Routed aux per counter
   output wire [7:0]  hardware_arm_input,       // Routed arm per counter
   output wire [7:0]  counter_phase_a_input,    // Routed phase A
   output wire [7:0]  counter_phase_b_input,    // Routed phase B
   output wire [7:0]  counter_index_input,      // Routed index
   output wire [7:0]  counter_sample_input,     // Routed sample clock
   output reg         input_sample_clock,       // Routed DI sample clock
   output reg         input_sample_timebase,    // Routed DI timebase
   output reg         input_reference_trigger,  // Routed DI reference trigger
   output reg         output_sample_clock_ext   // Routed external DO sample clock
);

   // Register regions
   localparam [3:0] REG_NONE = 4'h0;
   localparam [3:0] REG_TCFG = 4'h1;
   localparam [3:0] REG_ROUT = 4'h2;
   localparam [3:0] REG_ENG  = 4'h3;
   localparam [3:0] REG_SO0  = 4'h4;
   localparam [3:0] REG_SO1  = 4'h5;
   localparam [3:0] REG_SI0  = 4'h6;
   localparam [3:0] REG_SI1  = 4'h7;
   localparam [3:0] REG_FN   = 4'h8;
   localparam [3:0] REG_FRT  = 4'h9;

   reg  [11:0] term_cfg [0:39];   // Per-terminal configuration
   reg  [5:0]  route [0:63];      // Counter input selectors, index {ctr,slot}
   reg  [5:0]  eng_route [0:3];   // Engine selectors
   reg  [39:0] static_out;        // Static output ports 0 and 1
   reg  [9:0]  custom_n;          // Custom filter sample count
   reg  [7:0]  slow_cnt;          // Slow filter clock divider
   reg         slow_tick;         // Slow filter clock pulse
   reg         ph_valid;          // Data phase pending
   reg         ph_write;          // Pending phase is a write
   reg  [3:0]  ph_region;         // Region of the pending phase
   reg  [11:0] ph_addr;           // Address of the pending phase
   reg  [31:0] next_hrdata;       // Read data for the next edge
   reg  [63:0] routed;            // Registered counter inputs
   reg  [39:0] cond_d;            // Conditioned levels, one cycle old
   reg  [39:0] term_val;          // Level or edge pulse per terminal
   reg  [63:0] next_routed;       // Counter inputs before the register
   wire [39:0] filt;              // Debounced terminal levels
   wire [39:0] cond;              // Debounced levels after polarity
   wire        addr_take;         // Address phase accepted
   wire [3:0]  addr_region;       // Region of the address phase
   wire [3:0]  role_slot;         // Slot for a functional route write
   integer     i;                 // Loop index
   integer     k;                 // Route word index for reads

   // Map a byte address to a register region
   function [3:0] trm_decode;
      input [31:0] a;
      begin
         if (a[31:12] != 20'h00000 || a[1:0] != 2'h0) begin
            trm_decode = REG_NONE;
         end else if (a[11:0] <= `TRM_TERM_CFG_LAST) begin
            trm_decode = REG_TCFG;
         end else if (a[11:0] >= `TRM_ROUTE_BASE && a[11:0] <= `TRM_ROUTE_LAST) begin
            trm_decode = REG_ROUT;
         end else begin
            case (a[11:0])
               `TRM_ENGINE_ROUTE: trm_decode = REG_ENG;
               `TRM_STATIC_OUT0:  trm_decode = REG_SO0;
               `TRM_STATIC_OUT1:  trm_decode = REG_SO1;
               `TRM_STATIC_IN0:   trm_decode = REG_SI0;
               `TRM_STATIC_IN1:   trm_decode = REG_SI1;
               `TRM_FILTER_N:     trm_decode = REG_FN;
               `TRM_FUNC_ROUTE:   trm_decode = REG_FRT;
               default:           trm_decode = REG_NONE;
            endcase
         end
      end
   endfunction

   // Reset routing of a counter input; unrouted slots tie low
   function [5:0] trm_route_default;
      input integer ctr;
      input integer slot;
      begin
         case (slot)
            0, 4:    trm_route_default = 6'h27 - ctr[5:0] * 6'h04;
            5:       trm_route_default = 6'h25 - ctr[5:0] * 6'h04;
            1, 6:    trm_route_default = 6'h26 - ctr[5:0] * 6'h04;
            default: trm_route_default = `TRM_SEL_NONE;
         endcase
      end
   endfunction

   // Reset configuration of a terminal: counter outputs on 36-4k
   function [11:0] trm_cfg_default;
      input integer t;
      reg [3:0] osel;
      begin
         osel = 4'h0;
         if (t >= 8 && t <= 36 && ((36 - t) % 4) == 0) begin
            // Terminal 36 selects counter 0, terminal 8 counter 7
            osel = 4'h9 - t[5:2];
            trm_cfg_default = {osel, 6'h00, `TRM_FN_TIMING_OUT};
         end else begin
            trm_cfg_default = 12'h000;
         end
      end
   endfunction

   // Functional selector to counter input slot; bit 3 flags an unknown code
   function [3:0] trm_role_slot;
      input [3:0] role;
      begin
         case (role)
            4'h0:    trm_role_slot = {1'b0, `TRM_SLOT_GATE};
            4'h1:    trm_role_slot = {1'b0, `TRM_SLOT_B};
            4'h2:    trm_role_slot = {1'b0, `TRM_SLOT_SOURCE};
            4'h3:    trm_role_slot = {1'b0, `TRM_SLOT_ARM};
            4'h4:    trm_role_slot = {1'b0, `TRM_SLOT_A};
            4'h5:    trm_role_slot = {1'b0, `TRM_SLOT_B};
            4'h6:    trm_role_slot = {1'b0, `TRM_SLOT_INDEX};
            4'h7:    trm_role_slot = {1'b0, `TRM_SLOT_AUX};
            4'h8:    trm_role_slot = {1'b0, `TRM_SLOT_GATE};
            4'h9:    trm_role_slot = {1'b0, `TRM_SLOT_GATE};
            4'ha:    trm_role_slot = {1'b0, `TRM_SLOT_GATE};
            4'hb:    trm_role_slot = {1'b0, `TRM_SLOT_GATE};
            4'hc:    trm_role_slot = {1'b0, `TRM_SLOT_SOURCE};
            4'hd:    trm_role_slot = {1'b0, `TRM_SLOT_SAMPLE};
            default: trm_role_slot = 4'h8;
         endcase
      end
   endfunction

   // Pick one terminal's value; selectors past 39 read low
   function trm_pick;
      input [39:0] v;
      input [5:0]  s;
      begin
         trm_pick = (s < 6'd40) ? v[s] : 1'b0;
      end
   endfunction

   // One filter per terminal, ahead of all selectors
   genvar g;
   generate
      for (g = 0; g < 40; g = g + 1) begin : gen_term
         trm_filter u_filter (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .pin       (programmable_terminal_in[g]),
            .mode      (term_cfg[g][6:4]),
            .custom_n  (custom_n),
            .slow_tick (slow_tick),
            .filtered  (filt[g])
         );
         assign cond[g] = filt[g] ^ term_cfg[g][`TRM_CFG_INV_BIT];
      end
   endgenerate

   // Slow filter clock from hclk
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slow_cnt  <= 8'h00;
         slow_tick <= 1'b0;
      end else if (slow_cnt == `TRM_SLOW_CYCLES - 1) begin
         slow_cnt  <= 8'h00;
         slow_tick <= 1'b1;
      end else begin
         slow_cnt  <= slow_cnt + 8'h01;
         slow_tick <= 1'b0;
      end
   end

   // Level mode passes the level; edge mode a one-cycle active edge pulse
   always @* begin
      for (i = 0; i < 40; i = i + 1) begin
         term_val[i] = term_cfg[i][`TRM_CFG_LEVEL_BIT] ? cond[i] : (cond[i] & ~cond_d[i]);
      end
   end

   // Any terminal to any counter input
   always @* begin
      for (i = 0; i < 64; i = i + 1) begin
         next_routed[i] = trm_pick(term_val, route[i]);
      end
   end

   // Register routed signals so every output comes from a flop
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cond_d                  <= 40'h0000000000;
         routed                  <= 64'h0000000000000000;
         input_sample_clock      <= 1'b0;
         input_sample_timebase   <= 1'b0;
         input_reference_trigger <= 1'b0;
         output_sample_clock_ext <= 1'b0;
      end else begin
         cond_d                  <= cond;
         routed                  <= next_routed;
         input_sample_clock      <= trm_pick(term_val, eng_route[0]);
         input_sample_timebase   <= trm_pick(term_val, eng_route[1]);
         input_reference_trigger <= trm_pick(term_val, eng_route[2]);
         output_sample_clock_ext <= trm_pick(term_val, eng_route[3]);
      end
   end

   // Eight inputs per counter, slot order source..sample
   generate
      for (g = 0; g < 8; g = g + 1) begin : gen_ctr
         assign counter_source_input[g]    = routed[g * 8 + 0];
         assign counter_gate_input[g]      = routed[g * 8 + 1];
         assign counter_auxiliary_input[g] = routed[g * 8 + 2];
         assign hardware_arm_input[g]      = routed[g * 8 + 3];
         assign counter_phase_a_input[g]   = routed[g * 8 + 4];
         assign counter_phase_b_input[g]   = routed[g * 8 + 5];
         assign counter_index_input[g]     = routed[g * 8 + 6];
         assign counter_sample_input[g]    = routed[g * 8 + 7];
      end
   endgenerate

   // Terminal drivers: enable and output mux
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         programmable_terminal_out <= 40'h0000000000;
         // Default counter output terminals drive from reset on
         programmable_terminal_oe  <= 40'h1111111100;
      end else begin
         for (i = 0; i < 40; i = i + 1) begin
            // Off for both input functions; the pad pull-down then holds the line
            programmable_terminal_oe[i] <= term_cfg[i][0];
            if (term_cfg[i][1:0] == `TRM_FN_STATIC_OUT) begin
               programmable_terminal_out[i] <= static_out[i];
            end else begin
               case (term_cfg[i][11:8])
                  `TRM_OSEL_OUT_SCLK:   programmable_terminal_out[i] <= ~output_sample_clock;
                  `TRM_OSEL_IN_SCLK:    programmable_terminal_out[i] <= input_sample_clock;
                  `TRM_OSEL_IN_REFTRG:  programmable_terminal_out[i] <= input_reference_trigger;
                  default: begin
                     // Codes 0..7 are counter outputs, the rest drive low
                     if (term_cfg[i][11]) begin
                        programmable_terminal_out[i] <= 1'b0;
                     end else begin
                        programmable_terminal_out[i] <= counter_output[term_cfg[i][10:8]];
                     end
                  end
               endcase
            end
         end
      end
   end

   // Bus address phase
   assign addr_take   = hsel & htrans[1] & hready;
   assign addr_region = trm_decode(haddr);
   assign role_slot   = trm_role_slot(hwdata[7:4]);

   // Read data chosen in the address phase, held through the data phase
   always @* begin
      next_hrdata = 32'h00000000;
      k = {28'h0000000, haddr[5:2]};
      case (addr_region)
         REG_TCFG: next_hrdata = {20'h00000, term_cfg[haddr[7:2]]};
         REG_ROUT: next_hrdata = {2'h0, route[k * 4 + 3], 2'h0, route[k * 4 + 2],
                                  2'h0, route[k * 4 + 1], 2'h0, route[k * 4]};
         REG_ENG:  next_hrdata = {2'h0, eng_route[3], 2'h0, eng_route[2],
                                  2'h0, eng_route[1], 2'h0, eng_route[0]};
         REG_SO0:  next_hrdata = static_out[31:0];
         REG_SO1:  next_hrdata = {24'h000000, static_out[39:32]};
         REG_SI0:  next_hrdata = filt[31:0];
         REG_SI1:  next_hrdata = {24'h000000, filt[39:32]};
         REG_FN:   next_hrdata = {22'h000000, custom_n};
         default:  next_hrdata = 32'h00000000;
      endcase
   end

   // Bus slave: capture address, answer with zero wait states
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h00000000;
         ph_valid  <= 1'b0;
         ph_write  <= 1'b0;
         ph_region <= REG_NONE;
         ph_addr   <= 12'h000;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) begin
            ph_valid  <= addr_take;
            ph_write  <= hwrite;
            ph_region <= addr_region;
            ph_addr   <= haddr[11:0];
            if (addr_take && !hwrite) begin
               hrdata <= next_hrdata;
            end
         end
      end
   end

   // Register writes in the data phase; reset gives the default routing
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (i = 0; i < 40; i = i + 1) begin
            term_cfg[i] <= trm_cfg_default(i);
         end
         for (i = 0; i < 64; i = i + 1) begin
            route[i] <= trm_route_default(i / 8, i % 8);
         end
         for (i = 0; i < 4; i = i + 1) begin
            eng_route[i] <= `TRM_SEL_NONE;
         end
         static_out <= 40'h0000000000;
         custom_n   <= `TRM_N_CUSTOM_RESET;
      end else if (ph_valid && ph_write) begin
         case (ph_region)
            REG_TCFG: term_cfg[ph_addr[7:2]] <= hwdata[11:0];
            REG_ROUT: begin
               // Direct replacement of four selectors of one counter
               for (i = 0; i < 4; i = i + 1) begin
                  route[ph_addr[5:2] * 4 + i] <= hwdata[i * 8 +: 6];
               end
            end
            REG_ENG: begin
               for (i = 0; i < 4; i = i + 1) begin
                  eng_route[i] <= hwdata[i * 8 +: 6];
               end
            end
            REG_SO0:  static_out[31:0]  <= hwdata;
            REG_SO1:  static_out[39:32] <= hwdata[7:0];
            REG_FN:   custom_n          <= hwdata[9:0];
            REG_FRT: begin
               // Unknown functional codes are ignored
               if (!role_slot[3]) begin
                  route[{hwdata[2:0], role_slot[2:0]}] <= hwdata[13:8];
               end
            end
            default: begin
               // Read-only and unmapped writes are dropped
            end
         endcase
      end
   end

endmodule // trm_matrix

// ==== trm_defines.vh ====
// Purpose: Shared constants of the terminal routing matrix (map, fields, resets, timing)
// Assumes: 32-bit AHB-Lite register bus, 20 MHz hclk
// Notes:   Header only; definitions, no logic
`ifndef TRM_DEFINES_VH
`define TRM_DEFINES_VH

// Terminal and counter counts
`define TRM_NUM_TERM        40
`define TRM_NUM_CTR         8
`define TRM_NUM_SLOT        8
`define TRM_SEL_NONE        6'h3f

// Register byte addresses
`define TRM_TERM_CFG_BASE   12'h000
`define TRM_TERM_CFG_LAST   12'h09c
`define TRM_ROUTE_BASE      12'h100
`define TRM_ROUTE_LAST      12'h13c
`define TRM_ENGINE_ROUTE    12'h140
`define TRM_STATIC_OUT0     12'h180
`define TRM_STATIC_OUT1     12'h184
`define TRM_STATIC_IN0      12'h188
`define TRM_STATIC_IN1      12'h18c
`define TRM_FILTER_N        12'h190
`define TRM_FUNC_ROUTE      12'h194

// Terminal configuration fields
`define TRM_CFG_FUNC_LSB    0
`define TRM_CFG_INV_BIT     2
`define TRM_CFG_LEVEL_BIT   3
`define TRM_CFG_FILT_LSB    4
`define TRM_CFG_OSEL_LSB    8

// Terminal function codes; bit 0 set means the driver is on
`define TRM_FN_STATIC_IN    2'h0
`define TRM_FN_STATIC_OUT   2'h1
`define TRM_FN_TIMING_IN    2'h2
`define TRM_FN_TIMING_OUT   2'h3

// Output signal select codes (0..7 are counter outputs)
`define TRM_OSEL_OUT_SCLK   4'h8
`define TRM_OSEL_IN_SCLK    4'h9
`define TRM_OSEL_IN_REFTRG  4'ha

// Counter input slots
`define TRM_SLOT_SOURCE     3'h0
`define TRM_SLOT_GATE       3'h1
`define TRM_SLOT_AUX        3'h2
`define TRM_SLOT_ARM        3'h3
`define TRM_SLOT_A          3'h4
`define TRM_SLOT_B          3'h5
`define TRM_SLOT_INDEX      3'h6
`define TRM_SLOT_SAMPLE     3'h7

// Filter modes and their sample counts
`define TRM_FILT_NONE       3'h0
`define TRM_FILT_SHORT      3'h1
`define TRM_FILT_MEDIUM     3'h2
`define TRM_FILT_HIGH       3'h3
`define TRM_FILT_CUSTOM     3'h4
`define TRM_N_SHORT         10'h009
`define TRM_N_MEDIUM        10'h200
`define TRM_N_HIGH          10'h100
`define TRM_N_CUSTOM_RESET  10'h005

// Timing: slow filter clock period and hclk period, both in ns
`define TRM_SLOW_PERIOD_NS  10000
`define TRM_HCLK_PERIOD_NS  50
`define TRM_SLOW_CYCLES     (`TRM_SLOW_PERIOD_NS / `TRM_HCLK_PERIOD_NS)

`endif

// ==== trm_filter.v ====
// Purpose: One terminal's input synchroniser and debouncing filter
// Assumes: Pin is asynchronous to hclk; slow_tick is a one-cycle pulse
// Notes:   Fast modes sample every hclk edge, high mode on slow_tick
`timescale 1ns/1ps
`include "trm_defines.vh"

module trm_filter (
   input  wire       hclk,       // System clock
   input  wire       hresetn,    // Async reset, active low
   input  wire       pin,        // Raw terminal level
   input  wire [2:0] mode,       // Filter mode
   input  wire [9:0] custom_n,   // Sample count for custom mode
   input  wire       slow_tick,  // Slow filter clock pulse
   output reg        filtered    // Debounced level
);

   reg       sync1;   // First stage, read only by sync2
   reg       sync2;   // Second stage
   reg       sync3;   // Third stage
   reg       stable;  // Level once stages two and three agree
   reg [9:0] count;   // Consecutive samples of a new level
   reg [9:0] need;    // Samples needed to pass
   wire      sample_en;

   // Only the slow preset waits for the slow filter clock
   assign sample_en = (mode == `TRM_FILT_HIGH) ? slow_tick : 1'b1;

   // Count needed for the selected preset
   always @* begin
      case (mode)
         `TRM_FILT_SHORT:  need = `TRM_N_SHORT;
         `TRM_FILT_MEDIUM: need = `TRM_N_MEDIUM;
         `TRM_FILT_HIGH:   need = `TRM_N_HIGH;
         `TRM_FILT_CUSTOM: need = (custom_n == 10'h000) ? 10'h001 : custom_n;
         default:          need = 10'h001;
      endcase
   end

   // Three-stage synchroniser; a change counts when two and three agree
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1  <= 1'b0;
         sync2  <= 1'b0;
         sync3  <= 1'b0;
         stable <= 1'b0;
      end else begin
         sync1 <= pin;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3) begin
            stable <= sync3;
         end
      end
   end

   // Debounce: a new level passes after N consecutive samples
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filtered <= 1'b0;
         count    <= 10'h000;
      end else if (mode == `TRM_FILT_NONE) begin
         filtered <= stable;
         count    <= 10'h000;
      end else if (sample_en) begin
         if (stable == filtered) begin
            // A glitch back to the old level restarts the count
            count <= 10'h000;
         end else if (count + 10'h001 >= need) begin
            filtered <= stable;
            count    <= 10'h000;
         end else begin
            count <= count + 10'h001;
         end
      end
   end

endmodule // trm_filter

// ==== trm_matrix_assertions.sv ====
// Purpose: Port checks on trm_matrix
// Assumes: Reset defaults stand until a write is taken
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module trm_checker (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire        hreadyout,
   input wire        hresp,
   input wire [31:0] hrdata,
   input wire [39:0] programmable_terminal_out,
   input wire [39:0] programmable_terminal_oe,
   input wire [7:0]  counter_output,
   input wire [7:0]  counter_auxiliary_input,
   input wire        input_sample_clock
);
   reg        fresh; // No write since reset
   wire [7:0] tap;   // Terminal 36-4k per counter
   wire       wr = hsel && htrans[1] && hready && hwrite;
   // Any write may move a route, so default checks stop there
   always @(posedge hclk or negedge hresetn)
      if (!hresetn) fresh <= 1'b1;
      else if (wr) fresh <= 1'b0;
   for (genvar k = 0; k < 8; k++) begin : g_tap
      assign tap[k] = programmable_terminal_out[36-4*k];
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_READY: assert property (hreadyout) else $error("ready low");
   AST_OKAY: assert property (!hresp) else $error("bad response");
   AST_HOLD: assert property (!$past(hsel && htrans[1] && hready && !hwrite) |-> $stable(hrdata))
      else $error("read data moved");
   AST_DEF_OE: assert property (fresh |-> programmable_terminal_oe == 40'h1111111100)
      else $error("default enables");
   AST_DEF_OUT: assert property (fresh && $past(hresetn) |-> tap == $past(counter_output))
      else $error("default taps");
   AST_QUIET: assert property (fresh |-> (programmable_terminal_out & ~40'h1111111100) == 40'h0)
      else $error("idle terminal driven");
   AST_DEF_AUX: assert property (fresh |-> counter_auxiliary_input == 8'h0)
      else $error("aux routed");
   AST_DEF_ENG: assert property (fresh |-> !input_sample_clock)
      else $error("engine routed");
   C_WR: cover property (wr);
   C_RD: cover property (hsel && htrans[1] && hready && !hwrite);
   C_CFG: cover property ($fell(fresh));
endmodule // trm_checker
bind trm_matrix trm_checker u_chk (.*);

// ==== trm_partner.sv ====
// Purpose: Outside sources and loads on the terminals
// Assumes: Sources drive high or release the line
// Notes:   A released line sits at the pull-down level
`timescale 1ns/1ps
module trm_partner (
   input  wire [39:0] programmable_terminal_out,
   input  wire [39:0] programmable_terminal_oe,
   input  wire [39:0] src,
   output wire [39:0] programmable_terminal_in
);
   // Device wins where enabled, else source or pull-down
   assign programmable_terminal_in = (programmable_terminal_oe & programmable_terminal_out) |
      (~programmable_terminal_oe & src);
endmodule // trm_partner

// ==== tb_terminal_routing_matrix.sv ====
// Purpose: Directed bench for trm_matrix
// Assumes: hready tied to hreadyout
// Notes:   Pins resolved in trm_partner
`timescale 1ns/1ps
module tb_terminal_routing_matrix;
   reg         hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, output_sample_clock = 0;
   reg  [1:0]  htrans = 0;
   reg  [31:0] haddr = 0, hwdata = 0, q;
   reg  [39:0] src = 0;
   reg  [7:0]  counter_output = 0;
   reg  [63:0] e;
   wire        hreadyout, hresp, input_sample_clock, input_sample_timebase, input_reference_trigger;
   wire        output_sample_clock_ext;
   wire [31:0] hrdata;
   wire [39:0] programmable_terminal_in, programmable_terminal_out, programmable_terminal_oe;
   wire [7:0]  counter_source_input, counter_gate_input, counter_auxiliary_input, hardware_arm_input;
   wire [7:0]  counter_phase_a_input, counter_phase_b_input, counter_index_input, counter_sample_input;
   wire [63:0] sv = {counter_sample_input, counter_index_input, counter_phase_b_input, counter_phase_a_input,
                     hardware_arm_input, counter_auxiliary_input, counter_gate_input, counter_source_input};
   wire [55:0] rmap = 56'h70111126543051; // Slot per functional role
   integer     err_count = 0, cmp_count = 0, i, n;
   always #25 hclk = ~hclk;
   trm_matrix dut (.*, .hsize(3'h2), .hready(hreadyout));
   trm_partner u_far (.*);
   task chk(input string nm, input [63:0] g, x);
      cmp_count++;
      if (g !== x) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Next edge with hready high, bounded
   task wt;
      integer k;
      @(posedge hclk);
      for (k = 0; k < 50 && hreadyout !== 1'b1; k++) @(posedge hclk);
      if (k == 50) begin
         err_count++;
         end_of_test;
      end
   endtask
   task xfer(input w, input [31:0] a, d);
      @(posedge hclk);
      {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, a};
      wt;
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      wt;
      q = hrdata;
   endtask
   task rd(input [31:0] a, x);
      xfer(0, a, 0);
      chk("rdata", q, x);
   endtask
   task tk(input integer c);
      repeat (c) @(posedge hclk);
   endtask
   initial begin
      #2000000;
      err_count++;
      end_of_test;
   end
   initial begin
      tk(16);
      hresetn <= 1;
      counter_output <= 8'h5a;
      rd(32'h100, 32'h3f3f2627);
      rd(32'h138, 32'h3f3f0a0b);
      rd(32'h1f0, 0);
      for (i = 37; i < 40; i++) xfer(1, 4*i, 32'ha);
      counter_output <= 0;
      src <= 40'he000000020;
      xfer(1, 32'h014, 32'ha);
      tk(12);
      e = 64'h0001010100000101;
      chk("dflt", sv, e);
      for (i = 0; i < 14; i++) begin
         xfer(1, 32'h194, {18'h0, 6'h5, i[3:0], 4'h3});
         e[8*rmap[4*i+:4]+3] = 1'b1;
         tk(4);
         chk("role", sv, e);
      end
      xfer(1, 32'h140, 32'h05050505);
      tk(4);
      chk("engine", {input_sample_clock, input_sample_timebase, input_reference_trigger,
         output_sample_clock_ext}, 4'hf);
      $display("test routing done");
      xfer(1, 32'h09c, 32'he);
      tk(8);
      chk("inv", counter_source_input[0], 0);
      xfer(1, 32'h09c, 32'h2);
      src[39] <= 0;
      tk(20);
      src[39] <= 1;
      n = 0;
      repeat (20) begin
         @(posedge hclk);
         n += counter_source_input[0];
      end
      chk("edge", n, 1);
      $display("test polarity done");
      xfer(1, 32'h084, 32'h1);
      xfer(1, 32'h184, 32'h2);
      xfer(1, 32'h000, 32'h803);
      output_sample_clock <= 1;
      tk(3);
      chk("drive", {programmable_terminal_oe[33], programmable_terminal_out[33], programmable_terminal_oe[0],
         programmable_terminal_out[0]}, 4'he);
      rd(32'h188, 32'h20);
      $display("test static done");
      xfer(1, 32'h09c, 32'h1a);
      src[39] <= 0;
      tk(20);
      src[39] <= 1;
      tk(6);
      src[39] <= 0;
      n = 0;
      repeat (20) begin
         @(posedge hclk);
         n += counter_source_input[0];
      end
      chk("glitch", n, 0);
      src[39] <= 1;
      tk(20);
      chk("filt", counter_source_input[0], 1);
      $display("test filter done");
      end_of_test;
   end
endmodule // tb_terminal_routing_matrix
